// ### hw/rtcc_counter.sv
// real-time counter and calendar core with enable-protected configuration
`timescale 1ns/1ps
`default_nettype none
module rtcc_counter (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic cfg_we_i,
  input wire logic [rtcc_pkg::MODE_W-1:0] mode_i,
  input wire logic [3:0] prescaler_i,
  input wire logic clear_on_match_i,
  input wire logic hour_format_select_i,
  input wire logic [rtcc_pkg::EVENT_CONTROL_REGISTER_W-1:0] event_control_register_i,
  input wire logic wp_lock_i,
  input wire logic debug_halt_i,
  input wire logic debugger_access_i,
  input wire logic [rtcc_pkg::CORR_W-1:0] corr_i,
  input wire logic corr_sign_i,
  input wire logic count_we_i,
  input wire logic [rtcc_pkg::CNT_W-1:0] count_wdata_i,
  input wire logic [rtcc_pkg::CNT_W-1:0] compare0_i,
  input wire logic [rtcc_pkg::HALF_W-1:0] compare1_i,
  output logic [rtcc_pkg::CNT_W-1:0] count_o,
  output logic [rtcc_pkg::MODE_W-1:0] mode_o,
  output logic [3:0] prescaler_o,
  output logic clear_on_match_o,
  output logic hour_format_select_o,
  output logic [rtcc_pkg::EVENT_CONTROL_REGISTER_W-1:0] event_control_register_o,
  output logic enabled_o,
  output logic sync_busy_o,
  output logic overflow_o,
  output logic match0_o,
  output logic match1_o,
  output logic [rtcc_pkg::EV_PER_N-1:0] periodic_o,
  output logic overflow_ev_o,
  output logic match0_ev_o,
  output logic match1_ev_o,
  output logic [rtcc_pkg::EV_PER_N-1:0] periodic_ev_o
);
  import rtcc_pkg::*;

  // ========================================
  // input synchronisers
  // ========================================
  logic [3:0] sync1_r;
  logic [3:0] sync2_r;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      sync1_r <= '0;
      sync2_r <= '0;
    end else begin
      sync1_r <= {enable_i, debug_halt_i, debugger_access_i, wp_lock_i};
      sync2_r <= sync1_r;
    end
  end
  logic en_req;
  logic wp_active;
  assign en_req = sync2_r[3];
  assign wp_active = sync2_r[0] && !sync2_r[2] && !sync2_r[1];

  // ========================================
  // enable sequencing
  // ========================================
  rtcc_en_t en_state_r;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      en_state_r <= EN_OFF;
    end else begin
      case (en_state_r)
        EN_OFF: if (en_req) en_state_r <= EN_ON;
        EN_ON: if (!en_req) en_state_r <= EN_DISABLING;
        EN_DISABLING: en_state_r <= EN_OFF;
        default: en_state_r <= EN_OFF;
      endcase
    end
  end
  logic running;
  assign running = (en_state_r == EN_ON);

  // ========================================
  // enable-protected configuration
  // ========================================
  logic [MODE_W-1:0] mode_r;
  logic [3:0] presc_r;
  logic clr_r;
  logic h12_r;
  logic [EVENT_CONTROL_REGISTER_W-1:0] evc_r;
  logic pend_r;
  // held write keeps the full four-bit prescaler select, not a truncated copy
  logic [MODE_W+4+2+EVENT_CONTROL_REGISTER_W-1:0] pend_data_r;
  logic [MODE_W+4+2+EVENT_CONTROL_REGISTER_W-1:0] wr_data;
  logic cfg_ok;
  assign wr_data = {mode_i, prescaler_i, clear_on_match_i, hour_format_select_i,
    event_control_register_i};
  assign cfg_ok = (en_state_r == EN_OFF) && !en_req && !wp_active;

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      pend_r <= 1'b0;
      pend_data_r <= '0;
    end else if (cfg_we_i && en_state_r == EN_DISABLING && !wp_active) begin
      pend_r <= 1'b1;
      pend_data_r <= wr_data;
    end else if (en_state_r == EN_OFF) begin
      pend_r <= 1'b0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      mode_r <= MODE_WIDE;
      presc_r <= '0;
      clr_r <= 1'b0;
      h12_r <= 1'b0;
      evc_r <= '0;
    end else if (cfg_we_i && cfg_ok) begin
      mode_r <= mode_i;
      presc_r <= prescaler_i;
      clr_r <= clear_on_match_i;
      h12_r <= hour_format_select_i;
      evc_r <= event_control_register_i;
    end else if (pend_r && en_state_r == EN_OFF) begin
      {mode_r, presc_r, clr_r, h12_r, evc_r} <= pend_data_r;
    end
  end

  // ========================================
  // prescaler
  // ========================================
  logic tick;
  logic [PRESC_W-1:0] taps;
  rtcc_prescaler #(.W(PRESC_W), .CW(CORR_W)) u_presc (
    .clock_i(clock_i),
    .reset_i(reset_i),
    .run_i(running),
    .div_sel_i(presc_r),
    .corr_i(corr_i),
    .corr_sign_i(corr_sign_i),
    .tick_o(tick),
    .taps_o(taps)
  );

  // ========================================
  // calendar next value
  // ========================================
  function automatic logic [4:0] days_in(input logic [3:0] mon, input logic [5:0] yr);
    logic [4:0] d;
    d = 5'h1F;
    case (mon)
      4'h4, 4'h6, 4'h9, 4'hB: d = 5'h1E;
      // leap years every fourth year
      MON_FEB: d = ((yr[1:0] & LEAP_MASK) == 2'h0) ? 5'h1D : 5'h1C;
      default: d = 5'h1F;
    endcase
    return d;
  endfunction : days_in

  logic [CNT_W-1:0] cnt_r;
  logic [CNT_W-1:0] cal_nxt;
  logic cal_wrap;
  always_comb begin
    logic [5:0] s;
    logic [5:0] mi;
    logic [4:0] h;
    logic pm;
    logic [4:0] d;
    logic [3:0] mo;
    logic [5:0] y;
    s = cnt_r[SEC_LSB +: 6];
    mi = cnt_r[MIN_LSB +: 6];
    // in 12-hour form the top hour bit is the afternoon flag
    h = h12_r ? {1'b0, cnt_r[HR_LSB +: 4]} : cnt_r[HR_LSB +: 5];
    pm = h12_r && cnt_r[PM_BIT];
    d = cnt_r[DAY_LSB +: 5];
    mo = cnt_r[MON_LSB +: 4];
    y = cnt_r[YEAR_LSB +: 6];
    cal_wrap = 1'b0;
    if (s != SEC_MAX) begin
      s = s + 6'h01;
    end else begin
      s = '0;
      if (mi != MIN_MAX) begin
        mi = mi + 6'h01;
      end else begin
        mi = '0;
        if (h12_r ? (h == HR12_MAX - 5'h01 && pm) : (h == HR24_MAX)) begin
          h = h12_r ? HR12_MAX : '0;
          pm = 1'b0;
          if (d != days_in(mo, y)) begin
            d = d + 5'h01;
          end else begin
            d = DAY_MIN;
            if (mo != MON_MAX) begin
              mo = mo + 4'h1;
            end else begin
              mo = MON_MIN;
              cal_wrap = (y == YEAR_MAX);
              y = y + 6'h01;
            end
          end
        end else if (h12_r && h == HR12_MAX) begin
          h = HR12_MIN;
        end else if (h12_r && h == HR12_MAX - 5'h01) begin
          h = HR12_MAX;
          pm = 1'b1;
        end else begin
          h = h + 5'h01;
        end
      end
    end
    cal_nxt = {y, mo, d, (h12_r ? pm : h[4]), h[3:0], mi, s};
  end

  // ========================================
  // compare and counter
  // ========================================
  logic m0;
  logic m1;
  // one wide or two half compares
  always_comb begin
    case (mode_r)
      MODE_HALF: begin
        m0 = cnt_r[HALF_W-1:0] == compare0_i[HALF_W-1:0];
        m1 = cnt_r[HALF_W-1:0] == compare1_i;
      end
      default: begin
        m0 = cnt_r == compare0_i;
        m1 = 1'b0;
      end
    endcase
  end

  logic ovf;
  logic [CNT_W-1:0] cnt_nxt;
  always_comb begin
    ovf = 1'b0;
    cnt_nxt = cnt_r;
    case (mode_r)
      MODE_HALF: begin
        ovf = &cnt_r[HALF_W-1:0];
        cnt_nxt = {{(CNT_W-HALF_W){1'b0}}, cnt_r[HALF_W-1:0] + 16'h0001};
      end
      MODE_CAL: begin
        ovf = cal_wrap;
        cnt_nxt = cal_nxt;
      end
      default: begin
        ovf = &cnt_r;
        cnt_nxt = cnt_r + 32'h00000001;
      end
    endcase
    if (clr_r && m0) begin
      cnt_nxt = (mode_r == MODE_CAL) ? CAL_RESET : '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      cnt_r <= '0;
    end else if (count_we_i) begin
      cnt_r <= count_wdata_i;
    end else if (running && tick) begin
      // advance per tick only when running
      cnt_r <= cnt_nxt;
    end
  end

  // ========================================
  // flags and events
  // ========================================
  logic fire;
  assign fire = running && tick;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      overflow_o <= 1'b0;
      match0_o <= 1'b0;
      match1_o <= 1'b0;
      periodic_o <= '0;
      overflow_ev_o <= 1'b0;
      match0_ev_o <= 1'b0;
      match1_ev_o <= 1'b0;
      periodic_ev_o <= '0;
    end else begin
      overflow_o <= fire && ovf && !(clr_r && m0);
      match0_o <= fire && m0;
      match1_o <= fire && m1;
      periodic_o <= running ? taps[EV_PER_N-1:0] : '0;
      overflow_ev_o <= fire && ovf && !(clr_r && m0) && evc_r[EV_OVF];
      match0_ev_o <= fire && m0 && evc_r[EV_CMP0];
      match1_ev_o <= fire && m1 && evc_r[EV_CMP1];
      periodic_ev_o <= running ? (taps[EV_PER_N-1:0] & evc_r[EV_PER +: EV_PER_N]) : '0;
    end
  end

  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      count_o <= '0;
      mode_o <= MODE_WIDE;
      prescaler_o <= '0;
      clear_on_match_o <= 1'b0;
      hour_format_select_o <= 1'b0;
      event_control_register_o <= '0;
      enabled_o <= 1'b0;
      sync_busy_o <= 1'b0;
    end else begin
      count_o <= cnt_r;
      mode_o <= mode_r;
      prescaler_o <= presc_r;
      clear_on_match_o <= clr_r;
      hour_format_select_o <= h12_r;
      event_control_register_o <= evc_r;
      enabled_o <= running;
      sync_busy_o <= (en_state_r == EN_DISABLING) || pend_r || (en_req != running);
    end
  end
endmodule : rtcc_counter
`default_nettype wire

// ### hw/rtcc_pkg.sv
// package of constants and types for the real-time counter/calendar
package rtcc_pkg;
  localparam int PRESC_W = 10;
  localparam int CNT_W = 32;
  localparam int HALF_W = 16;
  localparam int MODE_W = 2;
  localparam int EVENT_CONTROL_REGISTER_W = 16;
  localparam int CORR_W = 8;
  localparam logic [1:0] MODE_WIDE = 2'h0;
  localparam logic [1:0] MODE_HALF = 2'h1;
  localparam logic [1:0] MODE_CAL = 2'h2;
  // event control bit positions
  localparam int EV_OVF = 0;
  localparam int EV_CMP0 = 1;
  localparam int EV_CMP1 = 2;
  localparam int EV_PER = 8;
  localparam int EV_PER_N = 8;
  // calendar field limits
  localparam logic [5:0] SEC_MAX = 6'h3B;
  localparam logic [5:0] MIN_MAX = 6'h3B;
  localparam logic [4:0] HR24_MAX = 5'h17;
  localparam logic [4:0] HR12_MIN = 5'h01;
  localparam logic [4:0] HR12_MAX = 5'h0C;
  localparam logic [4:0] DAY_MIN = 5'h01;
  localparam logic [3:0] MON_MIN = 4'h1;
  localparam logic [3:0] MON_MAX = 4'hC;
  localparam logic [3:0] MON_FEB = 4'h2;
  localparam logic [5:0] YEAR_MAX = 6'h3F;
  localparam logic [1:0] LEAP_MASK = 2'h3;
  // calendar layout inside the 32-bit value
  localparam int SEC_LSB = 0;
  localparam int MIN_LSB = 6;
  localparam int HR_LSB = 12;
  localparam int PM_BIT = 16;
  localparam int DAY_LSB = 17;
  localparam int MON_LSB = 22;
  localparam int YEAR_LSB = 26;
  localparam logic [CNT_W-1:0] CAL_RESET = 32'h00420000;
  typedef enum logic [1:0] {EN_OFF, EN_ON, EN_DISABLING} rtcc_en_t;
endpackage : rtcc_pkg

// ### hw/rtcc_prescaler.sv
// 10-bit prescaler with digital rate correction
`timescale 1ns/1ps
`default_nettype none
module rtcc_prescaler #(
  parameter int W = rtcc_pkg::PRESC_W,
  parameter int CW = rtcc_pkg::CORR_W
) (
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic run_i,
  input wire logic [3:0] div_sel_i,
  input wire logic [CW-1:0] corr_i,
  input wire logic corr_sign_i,
  output logic tick_o,
  output logic [W-1:0] taps_o
);
  logic [W-1:0] div_r;
  logic [W-1:0] last_r;
  logic [CW-1:0] corr_acc_r;
  logic [CW:0] acc_sum;
  logic [W-1:0] rise;
  logic base_tick;

  assign acc_sum = {1'b0, corr_acc_r} + {1'b0, corr_i};
  assign rise = div_r & ~last_r;
  assign base_tick = (div_sel_i == 4'h0) ? 1'b1 : rise[div_sel_i - 4'h1];

  always_ff @(posedge clock_i) begin
    if (reset_i || !run_i) begin
      div_r <= '0;
      last_r <= '0;
    end else begin
      div_r <= div_r + 1'b1;
      last_r <= div_r;
    end
  end

  // correction drops one whole tick per accumulator wrap, or with corr_sign_i set and div_sel_i above 1 adds ticks on rise[0]
  always_ff @(posedge clock_i) begin
    if (reset_i || !run_i) begin
      corr_acc_r <= '0;
      tick_o <= 1'b0;
      taps_o <= '0;
    end else begin
      taps_o <= rise;
      if (base_tick) begin
        corr_acc_r <= acc_sum[CW-1:0];
        if (acc_sum[CW] && !corr_sign_i) begin
          tick_o <= 1'b0;
        end else begin
          tick_o <= 1'b1;
        end
      end else begin
        tick_o <= corr_sign_i && acc_sum[CW] && rise[0] && div_sel_i > 4'h1;
      end
    end
  end
endmodule : rtcc_prescaler
`default_nettype wire

// ### verification/rtcc_properties.sv
// port-level checker for the real-time counter core
`timescale 1ns/1ps
`default_nettype none
module rtcc_properties
  import rtcc_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire logic enable_i,
  input wire logic cfg_we_i,
  input wire logic [MODE_W-1:0] mode_i,
  input wire logic wp_lock_i,
  input wire logic debug_halt_i,
  input wire logic debugger_access_i,
  input wire logic count_we_i,
  input wire logic [CNT_W-1:0] count_o,
  input wire logic [MODE_W-1:0] mode_o,
  input wire logic [EVENT_CONTROL_REGISTER_W-1:0] event_control_register_o,
  input wire logic enabled_o,
  input wire logic sync_busy_o,
  input wire logic overflow_o,
  input wire logic match0_o,
  input wire logic [EV_PER_N-1:0] periodic_o,
  input wire logic overflow_ev_o,
  input wire logic match0_ev_o,
  input wire logic [EV_PER_N-1:0] periodic_ev_o
);
  // ==========================================
  // helper history
  // inputs pass a 2-FF sync, so the last three samples must agree
  logic [2:0] ok_r;
  logic [2:0] lk_r;
  logic [2:0] idle_r;
  wire ok_now = !enable_i && (!wp_lock_i || debug_halt_i || debugger_access_i);
  wire lk_now = wp_lock_i && !debug_halt_i && !debugger_access_i;
  always_ff @(posedge clock_i) begin
    if (reset_i) begin
      ok_r <= 3'h0;
      lk_r <= 3'h0;
    end else begin
      ok_r <= {ok_r[1:0], ok_now};
      lk_r <= {lk_r[1:0], lk_now};
    end
  end
  always_ff @(posedge clock_i) begin
    if (reset_i || enabled_o || count_we_i || cfg_we_i) begin
      idle_r <= 3'h0;
    end else if (idle_r != 3'h7) begin
      idle_r <= idle_r + 3'h1;
    end
  end
  // ==========================================
  // assertions
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (reset_i);
  a_cfg_write_taken: assert property (cfg_we_i && ok_now && &ok_r && !enabled_o && !sync_busy_o
    |-> ##2 mode_o == $past(mode_i, 2)) else $error("config write lost");
  a_cfg_lock_drop: assert property (cfg_we_i && lk_now && &lk_r
    |-> ##2 $stable(mode_o)) else $error("locked write taken");
  a_cfg_on_drop: assert property (enabled_o [*3]
    |-> $stable(mode_o) && $stable(event_control_register_o)) else $error("write while on");
  a_ovf_ev_gate: assert property (overflow_ev_o
    |-> overflow_o && event_control_register_o[EV_OVF]) else $error("overflow event ungated");
  a_match_ev_gate: assert property (match0_ev_o
    |-> match0_o && event_control_register_o[EV_CMP0]) else $error("match event ungated");
  a_per_ev_pass: assert property (enabled_o [*3]
    |-> periodic_ev_o == (periodic_o & event_control_register_o[15:8])) else $error("periodic event");
  a_off_quiet: assert property ((!enabled_o) [*3]
    |-> !overflow_o && periodic_o == '0) else $error("event while disabled");
  a_enable_rise: assert property ($rose(enable_i) ##1 enable_i [*5]
    |-> enabled_o) else $error("enable too slow");
  a_count_hold: assert property (idle_r == 3'h7 |-> $stable(count_o)) else $error("count moved");
endmodule : rtcc_properties
bind rtcc_counter rtcc_properties u_chk (.clock_i, .reset_i, .enable_i, .cfg_we_i, .mode_i,
  .wp_lock_i, .debug_halt_i, .debugger_access_i, .count_we_i, .count_o, .mode_o,
  .event_control_register_o, .enabled_o, .sync_busy_o, .overflow_o, .match0_o, .periodic_o,
  .overflow_ev_o, .match0_ev_o, .periodic_ev_o);
`default_nettype wire

// ### verification/tb_top.sv
// self-checking bench for the real-time counter core
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import rtcc_pkg::*;
  logic clock_i, reset_i, enable_i, cfg_we_i, clear_on_match_i, hour_format_select_i;
  logic wp_lock_i, debug_halt_i, debugger_access_i, corr_sign_i, count_we_i;
  logic [1:0] mode_i, mode_o;
  logic [3:0] prescaler_i, prescaler_o;
  logic [15:0] event_control_register_i, event_control_register_o, compare1_i, ev;
  logic [7:0] corr_i, periodic_o, periodic_ev_o;
  logic [31:0] count_wdata_i, compare0_i, count_o, a;
  logic clear_on_match_o, hour_format_select_o, enabled_o, sync_busy_o, overflow_o;
  logic match0_o, match1_o, overflow_ev_o, match0_ev_o, match1_ev_o;
  int n_fail, check_count, i, y;
  rtcc_counter rtcc_counter_inst (.*);
  initial begin
    clock_i = 1'b0;
    forever #50 clock_i = ~clock_i;
  end
  // ==========================================
  // tasks
  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #1;
  endtask : tick
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    check_count++;
    if (s !== e) begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, s, e);
    end
  endtask : chk
  task automatic cfg(input logic [1:0] m, input logic [3:0] p, input logic c, input logic [15:0] e);
    mode_i = m;
    prescaler_i = p;
    clear_on_match_i = c;
    event_control_register_i = e;
    cfg_we_i = 1'b1;
    tick(1);
    cfg_we_i = 1'b0;
    tick(2);
  endtask : cfg
  task automatic load(input logic [31:0] v);
    count_wdata_i = v;
    count_we_i = 1'b1;
    tick(1);
    count_we_i = 1'b0;
  endtask : load
  task automatic run(input logic e);
    enable_i = e;
    tick(8);
  endtask : run
  task automatic end_sim;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : end_sim
  function automatic logic [31:0] cal(input int yr, mo, d, h, mi, s);
    return (yr << YEAR_LSB) | (mo << MON_LSB) | (d << DAY_LSB) | (h << HR_LSB) | (mi << 6) | s;
  endfunction : cal
  // ==========================================
  // tests
  initial begin
    {enable_i, cfg_we_i, clear_on_match_i, hour_format_select_i, wp_lock_i} = '0;
    {debug_halt_i, debugger_access_i, corr_sign_i, count_we_i, corr_i} = '0;
    {mode_i, prescaler_i, event_control_register_i, compare1_i} = '0;
    {count_wdata_i, compare0_i} = '0;
    n_fail = 0;
    check_count = 0;
    reset_i = 1'b1;
    void'($urandom(69677));
    tick(8);
    reset_i = 1'b0;
    tick(1);
    chk(count_o, 32'h00000000);
    chk({mode_o, enabled_o}, 32'h00000000);
    repeat (4) begin
      a = $urandom % 3;
      y = $urandom % 11;
      ev = $urandom;
      cfg(a[1:0], y[3:0], ev[3], ev);
      chk({mode_o, prescaler_o, event_control_register_o}, {a[1:0], y[3:0], ev});
    end
    // locked write dropped, then accepted under halt or debugger
    for (i = 0; i < 2; i++) begin
      cfg(MODE_WIDE, 4'h0, 1'b0, 16'h0000);
      wp_lock_i = 1'b1;
      tick(3);
      cfg(MODE_CAL, 4'h0, 1'b0, 16'h0000);
      chk(mode_o, MODE_WIDE);
      {debug_halt_i, debugger_access_i} = i ? 2'b01 : 2'b10;
      tick(3);
      cfg(MODE_CAL, 4'h0, 1'b0, 16'h0000);
      chk(mode_o, MODE_CAL);
      {wp_lock_i, debug_halt_i, debugger_access_i} = '0;
    end
    cfg(MODE_WIDE, 4'h0, 1'b0, 16'hFFFF);
    run(1);
    cfg(MODE_HALF, 4'h3, 1'b1, 16'h0000);
    chk({mode_o, event_control_register_o}, {MODE_WIDE, 16'hFFFF});
    a = count_o;
    tick(1);
    chk(count_o, a + 1);
    load(32'hFFFFFFF0);
    for (i = 0; i < 40 && overflow_o !== 1'b1; i++) tick(1);
    chk({overflow_o, overflow_ev_o, count_o[31:4]}, {2'b11, 28'hFFFFFFF});
    run(0);
    compare0_i = 20 + $urandom % 20;
    cfg(MODE_WIDE, 4'h0, 1'b1, 16'hFFFF);
    load(0);
    run(1);
    for (i = 0; i < 80 && match0_o !== 1'b1; i++) tick(1);
    chk(match0_ev_o, 1);
    tick(3);
    chk(count_o < 6, 1);
    run(0);
    compare1_i = 50 + $urandom % 100;
    cfg(MODE_HALF, 4'h0, 1'b0, 16'hFFFF);
    load(0);
    run(1);
    for (i = 0; i < 300 && match1_o !== 1'b1; i++) tick(1);
    chk({match1_o, match1_ev_o, count_o[31:16]}, {2'b11, 16'h0});
    // write lands in the one-cycle disabling state and is applied once off
    enable_i = 1'b0;
    tick(3);
    cfg(MODE_CAL, 4'h0, 1'b0, 16'h0000);
    chk(mode_o, MODE_CAL);
    run(1);
    for (y = 0; y < 2; y++) begin
      load(cal(y, 2, 28, 23, 59, 59));
      tick(4);
      chk(count_o[25:17], y ? {4'h3, 5'h01} : {4'h2, 5'h1D});
    end
    // 12-hour form: 11:59:59 in the afternoon of the last day rolls to 12 at night
    run(0);
    hour_format_select_i = 1'b1;
    cfg(MODE_CAL, 4'h0, 1'b0, 16'h0000);
    chk(hour_format_select_o, 1'b1);
    run(1);
    load(cal(0, 12, 31, 27, 59, 59));
    tick(4);
    chk(count_o[31:12], {6'h01, 4'h1, 5'h01, 1'b0, 4'hC});
    end_sim();
  end
  initial begin
    #2000000;
    n_fail++;
    end_sim();
  end
endmodule : tb_top
`default_nettype wire
